// >>> rtl/sht_ports.sv
// Purpose: TDM data port, D-channel port, serial control port and sync pins
// Assumes: Core logic on MCLK supplies frame data and interrupt words
// Notes: Bit clock is derived from MCLK by an NCO when the device is master
// What this block does
// - Master bit clock: five rates, line-locked
// - Master select sets bit clock direction
// - Format 4 shifts at half bit rate
// - Sample transmit data on falling edges, slots
// - D port enabled: only B1, B2 sampled
// - Continuous D: 16 kHz clock, edges for data
// - D clock synchronous with master bit clock
// - TDM D output on rising edges in slot
// - TDM D input on falling edges in slot
// - Control clock any polarity, asynchronous, two modes
// - Two bytes per control access
// - Control output floats while select is high
// - Select high ignores control interface activity
// - Transmit superframe sync rise marks superframe
// - Receive superframe sync only when enabled
// - Wake tone while down pulls detect low
// - Interrupt requests a read; queued data follows
// - Interrupt freed at select low, re-armed high
// - Frame sync is 8 kHz frame start strobe
`timescale 1ns/1ps
`include "sht_defs.svh"
module sht_ports import sht_pkg::*; #(
   parameter int FRAME_CNT_W = 10,
   parameter int IRQ_DEPTH = `SHT_IRQ_DEPTH
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Configuration
   input wire logic CLOCK_MASTER_SELECT,
   input wire logic [2:0] CLK_RATE_SEL,
   input wire logic [1:0] FORMAT_SEL,
   input wire logic [FRAME_CNT_W-1:0] B_SLOT_START,
   input wire logic [FRAME_CNT_W-1:0] D_SLOT_START,
   input wire logic DCHAN_PORT_EN,
   input wire logic DCHAN_CONT_MODE,
   input wire logic [15:0] FREQ_TRIM,
   input wire logic NT_MODE,
   input wire logic SUPERFRAME_DIR_SEL,
   input wire logic RX_SUPERFRAME_OUT_EN,
   input wire logic CTRL_EDGE_MODE,
   // Bit clock and frame sync pins
   input wire logic BIT_CLOCK_IN,
   output logic BIT_CLOCK_OUT,
   output logic BIT_CLOCK_OE,
   input wire logic FRAME_SYNC_A_IN,
   output logic FRAME_SYNC_A_OUT,
   output logic FRAME_SYNC_A_OE,
   // TDM and D-channel pins
   input wire logic TDM_TX_DATA_IN,
   output logic DCHAN_CLOCK_OUT,
   output logic DCHAN_DATA_OUT,
   input wire logic DCHAN_DATA_IN,
   // Superframe pins
   input wire logic TX_SUPERFRAME_SYNC_IN,
   output logic TX_SUPERFRAME_SYNC_OUT,
   output logic TX_SUPERFRAME_SYNC_OE,
   output logic RX_SUPERFRAME_SYNC,
   // Serial control pins
   input wire logic CTRL_SERIAL_CLOCK,
   input wire logic CTRL_SELECT_N,
   input wire logic CTRL_SERIAL_IN,
   output logic CTRL_SERIAL_OUT,
   output logic CTRL_SERIAL_OUT_OE,
   output logic IRQ_OUT_N,
   output logic IRQ_OUT_N_OE,
   // Wake detect
   input wire logic POWERED_DOWN,
   input wire logic WAKE_TONE,
   output logic WAKE_DETECT_OUT_N,
   output logic WAKE_DETECT_OUT_N_OE,
   // Core side
   output logic [7:0] TX_B1,
   output logic [7:0] TX_B2,
   output logic [1:0] TX_D,
   output logic TX_FRAME_VALID,
   input wire logic [1:0] RX_D_BITS,
   input wire logic TX_SF_START,
   output logic TX_SF_MARK,
   input wire logic RX_SF_START,
   output logic [15:0] CTRL_WORD,
   output logic CTRL_WORD_VALID,
   input wire logic IRQ_EVENT,
   input wire logic [15:0] IRQ_DATA
);
   localparam int AW = (IRQ_DEPTH > 1) ? $clog2(IRQ_DEPTH) : 1;
   localparam logic [AW:0] Q_FULL = (AW+1)'(IRQ_DEPTH);
   typedef logic [FRAME_CNT_W-1:0] sht_cnt_t;

   logic [7:0] pin_raw, s1, s2, s3, lvl;
   logic [31:0] nco;
   logic bclk_lvl, bclk_prev, rise, fall, start, fs_at_rise, master, fmt4, cont_en;
   sht_cnt_t cnt, next_cnt, frame_meas, frame_len, bi_now, bi_next, q1, q2, q3;
   logic [4:0] b_len, b_idx, d_idx_now, d_idx_next;
   logic samp_ok, drive_ok;
   logic [17:0] tx_acc;
   logic [1:0] d_acc, rx_d_lat, d_src;
   logic sf_tx_pend, sf_rx_pend, sfs_prev, sfs_dir_out;
   logic [15:0] rx_word, tx_word;
   logic done_tg_r, done_tg_f, tg_prev_r, tg_prev_f, cs_low;
   logic [15:0] q_mem [IRQ_DEPTH];
   logic [AW-1:0] wp, rp;
   logic [AW:0] q_cnt;
   logic push, pop;
   sht_irq_e state, next_state;

   function automatic logic [31:0] nco_inc(input logic [2:0] r);
      case (sht_rate_e'(r))
         SHT_RATE_512: nco_inc = `SHT_NCO_INC(`SHT_RATE1_KHZ);
         SHT_RATE_1536: nco_inc = `SHT_NCO_INC(`SHT_RATE2_KHZ);
         SHT_RATE_2048: nco_inc = `SHT_NCO_INC(`SHT_RATE3_KHZ);
         SHT_RATE_2560: nco_inc = `SHT_NCO_INC(`SHT_RATE4_KHZ);
         default: nco_inc = `SHT_NCO_INC(`SHT_RATE0_KHZ);
      endcase
   endfunction : nco_inc

   function automatic sht_cnt_t frame_bclks(input logic [2:0] r);
      case (sht_rate_e'(r))
         SHT_RATE_512: frame_bclks = sht_cnt_t'(`SHT_FRAME_BCLKS(`SHT_RATE1_KHZ));
         SHT_RATE_1536: frame_bclks = sht_cnt_t'(`SHT_FRAME_BCLKS(`SHT_RATE2_KHZ));
         SHT_RATE_2048: frame_bclks = sht_cnt_t'(`SHT_FRAME_BCLKS(`SHT_RATE3_KHZ));
         SHT_RATE_2560: frame_bclks = sht_cnt_t'(`SHT_FRAME_BCLKS(`SHT_RATE4_KHZ));
         default: frame_bclks = sht_cnt_t'(`SHT_FRAME_BCLKS(`SHT_RATE0_KHZ));
      endcase
   endfunction : frame_bclks

   function automatic logic in_slot(input sht_cnt_t bi, input sht_cnt_t st,
                                    input logic [4:0] len);
      in_slot = ({1'b0, bi} >= {1'b0, st}) &&
                ({1'b0, bi} < ({1'b0, st} + (FRAME_CNT_W+1)'(len)));
   endfunction : in_slot

   // Pin synchronisers: a change counts once stages two and three agree
   assign pin_raw = {done_tg_f, done_tg_r, CTRL_SELECT_N, DCHAN_DATA_IN, TDM_TX_DATA_IN,
                     TX_SUPERFRAME_SYNC_IN, FRAME_SYNC_A_IN, BIT_CLOCK_IN};
   always_ff @(posedge MCLK) begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         lvl <= `SHT_PIN_LVL_RST;
      end else begin
         lvl <= (s2 & s3) | (lvl & (s2 | s3));
      end
   end

   // Master bit clock from NCO, trimmed toward the recovered line clock
   assign master = CLOCK_MASTER_SELECT;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         nco <= `SHT_NCO_RST;
      end else begin
         nco <= nco + nco_inc(CLK_RATE_SEL) + {{16{FREQ_TRIM[15]}}, FREQ_TRIM};
      end
   end
   assign BIT_CLOCK_OUT = nco[31];
   assign BIT_CLOCK_OE = master;

   // Bit clock edges in either direction
   assign bclk_lvl = master ? nco[31] : lvl[0];
   always_ff @(posedge MCLK) begin
      if (RST) begin
         bclk_prev <= 1'b0;
      end else begin
         bclk_prev <= bclk_lvl;
      end
   end
   assign rise = bclk_lvl && !bclk_prev;
   assign fall = !bclk_lvl && bclk_prev;

   // Frame position counter
   assign frame_len = master ? frame_bclks(CLK_RATE_SEL) : frame_meas;
   assign start = master ? (cnt == frame_len - sht_cnt_t'(1)) : (lvl[1] && !fs_at_rise);
   assign next_cnt = start ? '0 : cnt + sht_cnt_t'(1);
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cnt <= '0;
         fs_at_rise <= 1'b0;
         frame_meas <= frame_bclks(3'h0);
      end else if (rise) begin
         cnt <= next_cnt;
         fs_at_rise <= lvl[1];
         if (start && !master) begin
            frame_meas <= cnt + sht_cnt_t'(1);
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         FRAME_SYNC_A_OUT <= 1'b0;
      end else if (rise) begin
         FRAME_SYNC_A_OUT <= master && start;
      end
   end
   assign FRAME_SYNC_A_OE = master;

   // Bit positions; format 4 uses two bit clocks per data bit
   assign fmt4 = (sht_fmt_e'(FORMAT_SEL) == SHT_FMT_4);
   assign bi_now = fmt4 ? (cnt >> 1) : cnt;
   assign bi_next = fmt4 ? (next_cnt >> 1) : next_cnt;
   assign samp_ok = !fmt4 || cnt[0];
   assign drive_ok = !fmt4 || !next_cnt[0];
   assign b_len = DCHAN_PORT_EN ? `SHT_B_SLOT_BITS : `SHT_BD_SLOT_BITS;
   assign b_idx = 5'(bi_now - B_SLOT_START);
   assign d_idx_now = 5'(bi_now - D_SLOT_START);
   assign d_idx_next = 5'(bi_next - D_SLOT_START);
   assign cont_en = DCHAN_PORT_EN && DCHAN_CONT_MODE;
   assign q1 = frame_len >> 2;
   assign q2 = q1 << 1;
   assign q3 = q2 + q1;

   // Transmit 2B+D capture
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tx_acc <= 18'h00000;
      end else if (fall && samp_ok && in_slot(bi_now, B_SLOT_START, b_len)) begin
         tx_acc[`SHT_BD_LAST - b_idx] <= lvl[3];
      end
   end

   // D input capture, TDM slot or continuous clock
   always_ff @(posedge MCLK) begin
      if (RST) begin
         d_acc <= 2'h0;
      end else if (cont_en) begin
         if (rise && next_cnt == q1) begin
            d_acc[1] <= lvl[4];
         end else if (rise && next_cnt == q3) begin
            d_acc[0] <= lvl[4];
         end
      end else if (DCHAN_PORT_EN && fall && samp_ok &&
                   in_slot(bi_now, D_SLOT_START, `SHT_D_SLOT_BITS)) begin
         d_acc[~d_idx_now[0]] <= lvl[4];
      end
   end

   // Frame hand-over to the core
   always_ff @(posedge MCLK) begin
      if (RST) begin
         TX_B1 <= 8'h00;
         TX_B2 <= 8'h00;
         TX_D <= 2'h0;
         rx_d_lat <= 2'h0;
         TX_FRAME_VALID <= 1'b0;
      end else begin
         TX_FRAME_VALID <= rise && start;
         if (rise && start) begin
            TX_B1 <= tx_acc[17:10];
            TX_B2 <= tx_acc[9:2];
            TX_D <= DCHAN_PORT_EN ? d_acc : tx_acc[1:0];
            rx_d_lat <= RX_D_BITS;
         end
      end
   end
   assign d_src = start ? RX_D_BITS : rx_d_lat;

   // D output and D clock, both stepped on bit clock rising edges
   always_ff @(posedge MCLK) begin
      if (RST) begin
         DCHAN_DATA_OUT <= 1'b0;
      end else if (rise) begin
         if (cont_en) begin
            if (next_cnt == '0) begin
               DCHAN_DATA_OUT <= d_src[1];
            end else if (next_cnt == q2) begin
               DCHAN_DATA_OUT <= d_src[0];
            end
         end else if (DCHAN_PORT_EN && drive_ok &&
                      in_slot(bi_next, D_SLOT_START, `SHT_D_SLOT_BITS)) begin
            DCHAN_DATA_OUT <= d_src[~d_idx_next[0]];
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         DCHAN_CLOCK_OUT <= 1'b0;
      end else if (!cont_en) begin
         DCHAN_CLOCK_OUT <= 1'b0;
      end else if (rise) begin
         DCHAN_CLOCK_OUT <= (next_cnt < q1) || (next_cnt >= q2 && next_cnt < q3);
      end
   end

   // Superframe sync, transmit and receive
   assign sfs_dir_out = NT_MODE || SUPERFRAME_DIR_SEL;
   assign TX_SUPERFRAME_SYNC_OE = sfs_dir_out;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         sf_tx_pend <= 1'b0;
         sf_rx_pend <= 1'b0;
      end else begin
         sf_tx_pend <= TX_SF_START || (sf_tx_pend && !(rise && start));
         sf_rx_pend <= RX_SF_START || (sf_rx_pend && !(rise && start));
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         TX_SUPERFRAME_SYNC_OUT <= 1'b0;
         RX_SUPERFRAME_SYNC <= 1'b0;
      end else begin
         if (!sfs_dir_out) begin
            TX_SUPERFRAME_SYNC_OUT <= 1'b0;
         end else if (rise && start) begin
            TX_SUPERFRAME_SYNC_OUT <= sf_tx_pend;
         end
         if (!RX_SUPERFRAME_OUT_EN) begin
            RX_SUPERFRAME_SYNC <= 1'b0;
         end else if (rise && start) begin
            RX_SUPERFRAME_SYNC <= sf_rx_pend;
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         sfs_prev <= 1'b0;
         TX_SF_MARK <= 1'b0;
      end else begin
         sfs_prev <= lvl[2];
         TX_SF_MARK <= !sfs_dir_out && lvl[2] && !sfs_prev;
      end
   end

   // Wake detect
   always_ff @(posedge MCLK) begin
      if (RST) begin
         WAKE_DETECT_OUT_N_OE <= 1'b0;
      end else if (!POWERED_DOWN) begin
         WAKE_DETECT_OUT_N_OE <= 1'b0;
      end else if (WAKE_TONE) begin
         WAKE_DETECT_OUT_N_OE <= 1'b1;
      end
   end
   assign WAKE_DETECT_OUT_N = 1'b0;

   // Serial control port
   sht_ctrl_shift u_ctrl (
      .ctrl_clk(CTRL_SERIAL_CLOCK),
      .sel_n(CTRL_SELECT_N),
      .din(CTRL_SERIAL_IN),
      .dout(CTRL_SERIAL_OUT),
      .dout_oe(CTRL_SERIAL_OUT_OE),
      .rst(RST),
      .edge_mode(CTRL_EDGE_MODE),
      .tx_word(tx_word),
      .rx_word(rx_word),
      .done_tg_r(done_tg_r),
      .done_tg_f(done_tg_f)
   );
   assign cs_low = !lvl[`SHT_CS_POS];
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tg_prev_r <= 1'b0;
         tg_prev_f <= 1'b0;
         CTRL_WORD <= 16'h0000;
         CTRL_WORD_VALID <= 1'b0;
      end else begin
         tg_prev_r <= lvl[6];
         tg_prev_f <= lvl[7];
         CTRL_WORD_VALID <= (lvl[6] != tg_prev_r) || (lvl[7] != tg_prev_f);
         if ((lvl[6] != tg_prev_r) || (lvl[7] != tg_prev_f)) begin
            CTRL_WORD <= rx_word;
         end
      end
   end

   // Interrupt word queue
   assign push = IRQ_EVENT && q_cnt != Q_FULL;
   assign pop = state != SHT_IRQ_BUSY && cs_low && q_cnt != '0;
   always_ff @(posedge MCLK) begin
      if (push) begin
         q_mem[wp] <= IRQ_DATA;
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         wp <= '0;
         rp <= '0;
         q_cnt <= '0;
      end else begin
         wp <= push ? AW'(({1'b0, wp} + 1) % IRQ_DEPTH) : wp;
         rp <= pop ? AW'(({1'b0, rp} + 1) % IRQ_DEPTH) : rp;
         q_cnt <= q_cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tx_word <= `SHT_NO_IRQ_WORD;
      end else if (!cs_low) begin
         tx_word <= (q_cnt != '0) ? q_mem[rp] : `SHT_NO_IRQ_WORD;
      end
   end

   // Interrupt request state
   always_comb begin
      next_state = state;
      case (state)
         SHT_IRQ_IDLE: begin
            if (cs_low) begin
               next_state = SHT_IRQ_BUSY;
            end else if (q_cnt != '0) begin
               next_state = SHT_IRQ_REQ;
            end
         end
         SHT_IRQ_REQ: begin
            if (cs_low) begin
               next_state = SHT_IRQ_BUSY;
            end
         end
         SHT_IRQ_BUSY: begin
            if (!cs_low) begin
               next_state = SHT_IRQ_IDLE;
            end
         end
         default: next_state = SHT_IRQ_IDLE;
      endcase
   end
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= SHT_IRQ_IDLE;
      end else begin
         state <= next_state;
      end
   end
   assign IRQ_OUT_N_OE = (state == SHT_IRQ_REQ);
   assign IRQ_OUT_N = 1'b0;

   // Checks
   a_irq_release: assert property (@(posedge MCLK) disable iff (RST)
      cs_low |=> !IRQ_OUT_N_OE) else $error("interrupt held during select low");
   a_irq_request: assert property (@(posedge MCLK) disable iff (RST)
      (state == SHT_IRQ_IDLE && !cs_low && q_cnt != '0) |=> IRQ_OUT_N_OE)
      else $error("pending interrupt not requested");
   a_co_float: assert property (@(posedge MCLK) disable iff (RST)
      CTRL_SELECT_N |-> !CTRL_SERIAL_OUT_OE) else $error("control output driven");
   a_wake_detect: assert property (@(posedge MCLK) disable iff (RST)
      (POWERED_DOWN && WAKE_TONE) ##1 !POWERED_DOWN |=> !WAKE_DETECT_OUT_N_OE)
      else $error("wake detect not released");
   a_rx_sf_gate: assert property (@(posedge MCLK) disable iff (RST)
      !RX_SUPERFRAME_OUT_EN |=> !RX_SUPERFRAME_SYNC) else $error("rx superframe not gated");
   a_fs_on_rise: assert property (@(posedge MCLK) disable iff (RST)
      $rose(FRAME_SYNC_A_OUT) |-> $past(rise) && cnt == '0) else $error("frame sync off edge");
   a_dchan_clock_out_off: assert property (@(posedge MCLK) disable iff (RST)
      !cont_en ##1 !cont_en |-> !DCHAN_CLOCK_OUT) else $error("D clock outside mode");
   a_dr_slot: assert property (@(posedge MCLK) disable iff (RST)
      (!cont_en && $changed(DCHAN_DATA_OUT)) |-> $past(rise))
      else $error("D output changed off rising edge");
   a_tx_sample: assert property (@(posedge MCLK) disable iff (RST)
      $changed(tx_acc) |-> $past(fall) && $past(samp_ok)) else $error("sample off falling");
endmodule : sht_ports

// >>> rtl/sht_defs.svh
// Purpose: Shared constants of the serial host and TDM port block
// Assumes: MCLK at 250 MHz
// Notes: Frequencies in kHz; NCO increments derived from them
`ifndef SHT_DEFS_SVH
`define SHT_DEFS_SVH
`define SHT_MCLK_KHZ 250000
`define SHT_FS_KHZ 8
`define SHT_RATE0_KHZ 256
`define SHT_RATE1_KHZ 512
`define SHT_RATE2_KHZ 1536
`define SHT_RATE3_KHZ 2048
`define SHT_RATE4_KHZ 2560
`define SHT_NCO_INC(khz) 32'(((64'(khz)) << 32) / 64'(`SHT_MCLK_KHZ))
`define SHT_FRAME_BCLKS(khz) 10'((khz) / `SHT_FS_KHZ)
`define SHT_B_SLOT_BITS 5'h10
`define SHT_BD_SLOT_BITS 5'h12
`define SHT_D_SLOT_BITS 5'h02
`define SHT_BD_LAST 5'h11
`define SHT_CTRL_BITS 5'h10
`define SHT_CTRL_LAST 5'h0F
`define SHT_IRQ_DEPTH 4
`define SHT_NO_IRQ_WORD 16'h0000
`define SHT_NCO_RST 32'h0000_0000
`define SHT_PIN_LVL_RST 8'h20
`define SHT_CS_POS 5
`endif

// >>> rtl/sht_pkg.sv
// Purpose: Types of the serial host and TDM port block
// Assumes: Nothing
// Notes: Irq request states are one-hot
package sht_pkg;
   typedef enum logic [1:0] {SHT_FMT_1 = 2'h0, SHT_FMT_2 = 2'h1, SHT_FMT_3 = 2'h2,
                             SHT_FMT_4 = 2'h3} sht_fmt_e;
   typedef enum logic [2:0] {SHT_RATE_256 = 3'h0, SHT_RATE_512 = 3'h1, SHT_RATE_1536 = 3'h2,
                             SHT_RATE_2048 = 3'h3, SHT_RATE_2560 = 3'h4} sht_rate_e;
   typedef enum logic [2:0] {SHT_IRQ_IDLE = 3'h1, SHT_IRQ_REQ = 3'h2,
                             SHT_IRQ_BUSY = 3'h4} sht_irq_e;
endpackage : sht_pkg

// >>> rtl/sht_ctrl_shift.sv
// Purpose: Serial control port shifter on the control clock
// Assumes: edge_mode stable while sel_n is low
// Notes: Select high clears the bit counters asynchronously
`timescale 1ns/1ps
`include "sht_defs.svh"
module sht_ctrl_shift (
   // Link side
   input wire logic ctrl_clk,
   input wire logic sel_n,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // Core side
   input wire logic rst,
   input wire logic edge_mode,
   input wire logic [15:0] tx_word,
   output logic [15:0] rx_word,
   output logic done_tg_r,
   output logic done_tg_f
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_f;
   logic [15:0] sh_r;
   logic [15:0] sh_f;
   logic [15:0] word_r;
   logic [15:0] word_f;
   logic [4:0] idx;

   // Rising edges: sample in mode 0, shift out in mode 1
   always_ff @(posedge ctrl_clk or posedge sel_n) begin
      if (sel_n) begin
         cnt_r <= 5'h00;
      end else if ((!edge_mode || cnt_f != 5'h00) && cnt_r != `SHT_CTRL_BITS) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // Falling edges: sample in mode 1, shift out in mode 0
   always_ff @(negedge ctrl_clk or posedge sel_n) begin
      if (sel_n) begin
         cnt_f <= 5'h00;
      end else if ((edge_mode || cnt_r != 5'h00) && cnt_f != `SHT_CTRL_BITS) begin
         cnt_f <= cnt_f + 5'h01;
      end
   end

   always_ff @(posedge ctrl_clk) begin
      sh_r <= {sh_r[14:0], din};
   end

   always_ff @(negedge ctrl_clk) begin
      sh_f <= {sh_f[14:0], din};
   end

   // Completed words, announced by a toggle
   always_ff @(posedge ctrl_clk or posedge rst) begin
      if (rst) begin
         word_r <= 16'h0000;
         done_tg_r <= 1'b0;
      end else if (!sel_n && !edge_mode && cnt_r == `SHT_CTRL_LAST) begin
         word_r <= {sh_r[14:0], din};
         done_tg_r <= ~done_tg_r;
      end
   end

   always_ff @(negedge ctrl_clk or posedge rst) begin
      if (rst) begin
         word_f <= 16'h0000;
         done_tg_f <= 1'b0;
      end else if (!sel_n && edge_mode && cnt_f == `SHT_CTRL_LAST) begin
         word_f <= {sh_f[14:0], din};
         done_tg_f <= ~done_tg_f;
      end
   end

   assign rx_word = edge_mode ? word_f : word_r;
   assign idx = edge_mode ? cnt_r : cnt_f;
   assign dout = (idx > 5'h0F) ? tx_word[0] : tx_word[4'hF - idx[3:0]];
   assign dout_oe = !sel_n;
endmodule : sht_ctrl_shift

// >>> sim/sht_host_model.sv
// Purpose: Host model for the serial control port
// Assumes: The bench calls one access at a time, gaps of 10 MCLK or more
// Notes: Clock runs only inside accesses; idle polarity follows the mode
`timescale 1ns/1ps
module sht_host_model (
   // Control pins
   output logic ctrl_serial_clock,
   output logic sel_n,
   output logic ci,
   input wire logic co,
   input wire logic co_oe
);
   initial begin
      ctrl_serial_clock = 1'b0;
      sel_n = 1'b1;
      ci = 1'b0;
   end
   // One access of n sample edges; rd collects the output bits
   task automatic access(input logic mode, input logic [15:0] wd, input int n,
                         output logic [15:0] rd);
      int k;
      rd = 16'h0000;
      ctrl_serial_clock = mode;
      #3.7 sel_n = 1'b0;
      for (k = 0; k < n; k++) begin
         ci = wd[15-k];
         #6 rd = {rd[14:0], (co_oe ? co : 1'bx)};
         ctrl_serial_clock = ~mode;
         #6 ctrl_serial_clock = mode;
      end
      #6 sel_n = 1'b1;
      ci = ~ci;
   endtask : access
endmodule : sht_host_model

// >>> sim/sht_ports_test.sv
// Purpose: Self-checking bench of the control port, interrupt and wake pins
// Assumes: Host model drives the control link at 12 ns
// Notes: One master and one slave frame start close the run
`timescale 1ns/1ps
module sht_ports_test;
   import sht_pkg::*;
   typedef struct {logic m; logic irq; logic [15:0] w;} sht_row_s;
   sht_row_s rows [4] = '{'{1'b0, 1'b0, 16'hA55A}, '{1'b1, 1'b1, 16'h5AA5},
                          '{1'b0, 1'b1, 16'h8001}, '{1'b1, 1'b0, 16'h7FFE}};
   logic mclk = 1'b0, rst = 1'b0, clock_master_select = 1'b0, pdn = 1'b0, wake = 1'b0, irq_ev = 1'b0;
   logic edge_m = 1'b0, lo = 1'b0, bck = 1'b0, fsi = 1'b0, sfi = 1'b0, nt = 1'b0, sfg = 1'b0;
   logic tdm = 1'b1, fs_o, fv_o, sfs_o, rsfs_o, mark_o;
   logic [7:0] b2_o;
   logic [1:0] d_o;
   logic [9:0] slot = 10'h000;
   logic [15:0] irq_dat = 16'h0000, trim = 16'h0000, rd, word_o, exp;
   logic word_v, co, co_oe, irq_oe, wk_oe, bck_oe, ctrl_serial_clock, sel_n, ci;
   int miscompares = 0, cmp_count = 0, cycles = 0, seen;
   always #2 mclk = ~mclk;
   always #244 bck = ~bck;
   sht_ports dut (.MCLK(mclk), .RST(rst), .CLOCK_MASTER_SELECT(clock_master_select), .CLK_RATE_SEL(3'h3),
      .FORMAT_SEL(2'h0), .B_SLOT_START(slot), .D_SLOT_START(slot), .DCHAN_PORT_EN(lo),
      .DCHAN_CONT_MODE(lo), .FREQ_TRIM(trim), .NT_MODE(nt), .SUPERFRAME_DIR_SEL(lo),
      .RX_SUPERFRAME_OUT_EN(lo), .CTRL_EDGE_MODE(edge_m), .BIT_CLOCK_IN(bck),
      .BIT_CLOCK_OUT(), .BIT_CLOCK_OE(bck_oe), .FRAME_SYNC_A_IN(fsi), .FRAME_SYNC_A_OUT(fs_o),
      .FRAME_SYNC_A_OE(), .TDM_TX_DATA_IN(tdm), .DCHAN_CLOCK_OUT(), .DCHAN_DATA_OUT(),
      .DCHAN_DATA_IN(lo), .TX_SUPERFRAME_SYNC_IN(sfi), .TX_SUPERFRAME_SYNC_OUT(sfs_o),
      .TX_SUPERFRAME_SYNC_OE(), .RX_SUPERFRAME_SYNC(rsfs_o), .CTRL_SERIAL_CLOCK(ctrl_serial_clock),
      .CTRL_SELECT_N(sel_n), .CTRL_SERIAL_IN(ci), .CTRL_SERIAL_OUT(co),
      .CTRL_SERIAL_OUT_OE(co_oe), .IRQ_OUT_N(), .IRQ_OUT_N_OE(irq_oe),
      .POWERED_DOWN(pdn), .WAKE_TONE(wake), .WAKE_DETECT_OUT_N(),
      .WAKE_DETECT_OUT_N_OE(wk_oe), .TX_B1(), .TX_B2(b2_o), .TX_D(d_o), .TX_FRAME_VALID(fv_o),
      .RX_D_BITS(2'h0), .TX_SF_START(sfg), .TX_SF_MARK(mark_o), .RX_SF_START(sfg),
      .CTRL_WORD(word_o), .CTRL_WORD_VALID(word_v), .IRQ_EVENT(irq_ev), .IRQ_DATA(irq_dat));
   sht_host_model host (.ctrl_serial_clock(ctrl_serial_clock), .sel_n(sel_n), .ci(ci), .co(co), .co_oe(co_oe));
   task automatic step();
      @(posedge mclk);
      #1;
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      cmp_count++;
      if (got !== want) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
         miscompares++;
      end
   endtask : chk
   task automatic wait_lvl(ref logic s, input logic v);
      int i;
      for (i = 0; i < 30 && s !== v; i++) step();
      chk({15'h0000, s}, {15'h0000, v});
   endtask : wait_lvl
   task automatic pulse_irq(input logic [15:0] d);
      step();
      irq_dat = d;
      irq_ev = 1'b1;
      step();
      irq_ev = 1'b0;
   endtask : pulse_irq
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      #1 rst = 1'b1;
      repeat (2) step();
      rst = 1'b0;
      step();
      chk({11'h000, word_v, irq_oe, wk_oe, co_oe, bck_oe}, 16'h0000);
      clock_master_select = 1'b1;
      step();
      chk({15'h0000, bck_oe}, 16'h0001);
      foreach (rows[i]) begin
         step();
         edge_m = rows[i].m;
         exp = 16'h0000;
         if (rows[i].irq) begin
            pulse_irq(~rows[i].w);
            exp = ~rows[i].w;
            wait_lvl(irq_oe, 1'b1);
         end
         host.access(rows[i].m, rows[i].w, 16, rd);
         chk(rd, exp);
         wait_lvl(word_v, 1'b1);
         chk(word_o, rows[i].w);
         chk({14'h0000, irq_oe, co_oe}, 16'h0000);
         repeat (12) step();
      end
      edge_m = 1'b0;
      host.access(1'b0, 16'h1234, 8, rd);
      seen = 0;
      repeat (20) begin
         step();
         if (word_v === 1'b1) seen++;
      end
      chk(16'(seen), 16'h0000);
      pulse_irq(16'hC3A5);
      pulse_irq(16'h3C5A);
      wait_lvl(irq_oe, 1'b1);
      host.access(1'b0, 16'h0F0F, 16, rd);
      chk(rd, 16'hC3A5);
      wait_lvl(irq_oe, 1'b1);
      repeat (12) step();
      edge_m = 1'b1;
      host.access(1'b1, 16'hF0F0, 16, rd);
      chk(rd, 16'h3C5A);
      pdn = 1'b1;
      wake = 1'b1;
      step();
      wake = 1'b0;
      wait_lvl(wk_oe, 1'b1);
      pdn = 1'b0;
      wait_lvl(wk_oe, 1'b0);
      nt = 1'b1;
      sfg = 1'b1;
      step();
      sfg = 1'b0;
      for (seen = 0; seen < 33000 && fs_o !== 1'b1; seen++) step();
      chk({sfs_o, fv_o, fs_o, rsfs_o, 2'h0, d_o, b2_o}, 16'hE3FF);
      clock_master_select = 1'b0;
      nt = 1'b0;
      @(negedge bck);
      step();
      fsi = 1'b1;
      sfi = 1'b1;
      seen = 0;
      repeat (130) begin
         step();
         seen += (fv_o === 1'b1) + 16 * (mark_o === 1'b1);
      end
      chk(16'(seen), 16'h0011);
      tally_and_finish();
   end
endmodule : sht_ports_test
